// *** fcs_pkg.sv ***
//**********************************************************************
// Shared constants of the flash command and status block
//**********************************************************************
package fcs_pkg;

   // Register byte offsets on the Wishbone bus
   localparam logic [7:0] OFS_STAT     = 8'h00;  // Command status flags
   localparam logic [7:0] OFS_CMD      = 8'h04;  // Command code
   localparam logic [7:0] OFS_ADDR     = 8'h08;  // Array address
   localparam logic [7:0] OFS_DATA     = 8'h0C;  // Array data byte
   localparam logic [7:0] OFS_DIV      = 8'h10;  // Clock divider
   localparam logic [7:0] OFS_PROT     = 8'h14;  // Protection base
   localparam logic [7:0] OFS_IRQ_STS  = 8'h18;  // Sticky events
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;  // Event mask

   // Status register field positions
   localparam int BIT_CBEF   = 7;  // Command buffer empty
   localparam int BIT_CCF    = 6;  // Command complete
   localparam int BIT_PVIOL  = 5;  // Protection violation
   localparam int BIT_ACCERR = 4;  // Access error
   localparam int BIT_BLANK  = 2;  // Blank check result

   // Divider and protection register fields
   localparam int DIV_W        = 7;   // Divider value width
   localparam int BIT_DIV_INIT = 7;   // Divider written flag
   localparam int BIT_PROT_EN  = 31;  // Protection enable

   // Command codes
   localparam logic [7:0] CMD_BLANK = 8'h01;  // Blank check
   localparam logic [7:0] CMD_PROG  = 8'h02;  // Single program
   localparam logic [7:0] CMD_BURST = 8'h03;  // Burst program
   localparam logic [7:0] CMD_PAGE  = 8'h04;  // Page erase
   localparam logic [7:0] CMD_MASS  = 8'h05;  // Mass erase

   // Interrupt event positions
   localparam int IRQ_DONE   = 0;  // All commands complete
   localparam int IRQ_PVIOL  = 1;  // Protection violation
   localparam int IRQ_ACCERR = 2;  // Access error
   localparam int IRQ_W      = 3;  // Event count

   // Reset values
   localparam logic [DIV_W-1:0] DIV_RST = 7'h00;  // Divider after reset

   // Array engine state
   typedef enum logic [1:0]
   {
      FCS_IDLE = 2'b01,  // No command running
      FCS_RUN  = 2'b10   // Array busy
   } fcs_run_t;

   // Command writing sequence
   typedef enum logic [2:0]
   {
      SEQ_NONE = 3'b001,  // Waiting for data write
      SEQ_DATA = 3'b010,  // Data written
      SEQ_CMD  = 3'b100   // Command written
   } fcs_seq_t;

endpackage : fcs_pkg

// *** fcs_flags.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Writing one to bit 7 launches command
// - Buffered burst handover clears buffer-empty flag
// - Only burst commands queue; one deep
// - Complete flag set when idle, nothing queued
// - Launch clears complete flag; writes ignored
// - Protected erase/program sets violation, command ignored
// - Writing one clears protection violation
// - Broken command sequence sets access error
// - Program/erase before divider set: access error
// - Stop during command sets access error
// - Access error: one clears, zero keeps
// - Blank check passing sets blank flag
// - Valid launch clears blank; writes ignored
// - Blank zero after completion means not erased
module fcs_flags
   import fcs_pkg::*;
#(
   parameter int AW = 16  // Array address width
)
(
   input  wire logic          mclk,        // System clock
   input  wire logic          resetn,      // Async reset, low active
   input  wire logic          wb_cyc_i,    // Bus cycle
   input  wire logic          wb_stb_i,    // Bus strobe
   input  wire logic          wb_we_i,     // Write enable
   input  wire logic [7:0]    wb_adr_i,    // Byte address
   input  wire logic [3:0]    wb_sel_i,    // Byte lanes
   input  wire logic [31:0]   wb_dat_i,    // Write data
   output logic      [31:0]   wb_dat_o,    // Read data
   output logic               wb_ack_o,    // Acknowledge
   output logic               irq_o,       // Level interrupt
   input  wire logic          stop_i,      // Processor enters stop
   input  wire logic          arr_done_i,  // Array finished command
   input  wire logic          arr_blank_i, // Array found fully erased
   output logic               arr_start_o, // Start pulse to array
   output logic               arr_abort_o, // Abort pulse to array
   output logic      [7:0]    arr_cmd_o,   // Command to array
   output logic      [AW-1:0] arr_addr_o,  // Address to array
   output logic      [7:0]    arr_data_o,  // Data to array
   output logic [DIV_W-1:0]   arr_div_o    // Programming clock divider
);

   //*******************************************************************
   // State
   //*******************************************************************
   typedef struct packed {
      logic             ack_ff;    // Bus acknowledge
      logic [31:0]      rdat_ff;   // Bus read data
      logic             cbef;      // Buffer empty flag
      logic             ccf;       // Complete flag
      logic             pviol;     // Protection violation
      logic             accerr;    // Access error
      logic             blank;     // Blank result
      fcs_seq_t         seq;       // Sequence position
      logic [7:0]       cmd;       // Staged command
      logic [AW-1:0]    addr;      // Staged address
      logic [7:0]       data;      // Staged data
      logic [DIV_W-1:0] div;       // Divider value
      logic             div_init;  // Divider written
      logic [AW-1:0]    prot_base; // Lowest protected address
      logic             prot_en;   // Protection on
      fcs_run_t         run;       // Engine state
      logic             run_burst; // Running command is burst
      logic             buf_valid; // Queued command held
      logic [7:0]       buf_cmd;   // Queued command
      logic [AW-1:0]    buf_addr;  // Queued address
      logic [7:0]       buf_data;  // Queued data
      logic             start;     // Start pulse
      logic             abort;     // Abort pulse
      logic [7:0]       a_cmd;     // Command at array
      logic [AW-1:0]    a_addr;    // Address at array
      logic [7:0]       a_data;    // Data at array
      logic [IRQ_W-1:0] irq_sts;   // Sticky events
      logic [IRQ_W-1:0] irq_mask;  // Event mask
      logic             irq;       // Interrupt output
   } fcs_state_t;

   fcs_state_t       st_ff;     // Registered state
   fcs_state_t       nxt_st;    // Next state
   logic             req;       // Bus request present
   logic             wr;        // Write takes effect
   logic             wr_lo;     // Write of low byte
   logic             launch;    // Launch write
   logic             launch_ok; // Launch accepted
   logic             launch_pv; // Launch hit protection
   logic             launch_ae; // Launch refused by error
   logic             is_burst;  // Staged command is burst
   logic             is_pe;     // Staged command programs or erases
   logic             prot_hit;  // Staged command hits protection
   logic             done;      // Array finished this cycle
   logic             xfer;      // Queued command handed over
   logic             stop_err;  // Stop while busy
   logic             valid_cmd; // Written code is known
   logic [IRQ_W-1:0] ev;        // New events

   //*******************************************************************
   // Next state
   //*******************************************************************
   always_comb
   begin
      nxt_st = st_ff;
      ev     = '0;
      req    = wb_cyc_i & wb_stb_i;
      // Writes act on the edge where ack is high
      wr     = req & st_ff.ack_ff & wb_we_i;
      wr_lo  = wr & wb_sel_i[0];
      nxt_st.ack_ff = req & ~st_ff.ack_ff;
      nxt_st.start  = 1'b0;
      nxt_st.abort  = 1'b0;
      is_burst = (st_ff.cmd == CMD_BURST);
      is_pe    = (st_ff.cmd != CMD_BLANK);
      valid_cmd = (wb_dat_i[7:0] == CMD_BLANK) || (wb_dat_i[7:0] == CMD_PROG) ||
                  (wb_dat_i[7:0] == CMD_BURST) || (wb_dat_i[7:0] == CMD_PAGE) || (wb_dat_i[7:0] == CMD_MASS);
      // Mass erase touches every block, so any protection hits it
      prot_hit = (st_ff.cmd == CMD_MASS) ? st_ff.prot_en :
                 (is_pe & st_ff.prot_en & (st_ff.addr >= st_ff.prot_base));
      launch = wr_lo & (wb_adr_i == OFS_STAT) & wb_dat_i[BIT_CBEF];
      // Refused: buffer full, sequence broken, divider unset, queue misuse
      launch_ae = launch & (~st_ff.cbef | (st_ff.seq != SEQ_CMD) |
                  (is_pe & ~st_ff.div_init) |
                  ((st_ff.run == FCS_RUN) & ~(st_ff.run_burst & is_burst)));
      launch_pv = launch & ~launch_ae & prot_hit;
      launch_ok = launch & ~launch_ae & ~prot_hit;
      done      = (st_ff.run == FCS_RUN) & arr_done_i;
      xfer      = st_ff.buf_valid & ((st_ff.run == FCS_IDLE) | done);
      stop_err  = stop_i & (st_ff.run == FCS_RUN);

      // Read data captured in the request cycle
      nxt_st.rdat_ff = '0;
      if (req & ~st_ff.ack_ff & ~wb_we_i)
      begin
         case (wb_adr_i)
            OFS_STAT:
            begin
               // Unused status bits stay zero
               nxt_st.rdat_ff[BIT_CBEF]   = st_ff.cbef;
               nxt_st.rdat_ff[BIT_CCF]    = st_ff.ccf;
               nxt_st.rdat_ff[BIT_PVIOL]  = st_ff.pviol;
               nxt_st.rdat_ff[BIT_ACCERR] = st_ff.accerr;
               nxt_st.rdat_ff[BIT_BLANK]  = st_ff.blank;
            end
            OFS_CMD:      nxt_st.rdat_ff[7:0]      = st_ff.cmd;
            OFS_ADDR:     nxt_st.rdat_ff[AW-1:0]   = st_ff.addr;
            OFS_DATA:     nxt_st.rdat_ff[7:0]      = st_ff.data;
            OFS_DIV:
            begin
               nxt_st.rdat_ff[DIV_W-1:0]    = st_ff.div;
               nxt_st.rdat_ff[BIT_DIV_INIT] = st_ff.div_init;
            end
            OFS_PROT:
            begin
               nxt_st.rdat_ff[AW-1:0]      = st_ff.prot_base;
               nxt_st.rdat_ff[BIT_PROT_EN] = st_ff.prot_en;
            end
            OFS_IRQ_STS:  nxt_st.rdat_ff[IRQ_W-1:0] = st_ff.irq_sts;
            OFS_IRQ_MASK: nxt_st.rdat_ff[IRQ_W-1:0] = st_ff.irq_mask;
            default:      nxt_st.rdat_ff = '0;  // Unmapped reads zero
         endcase
      end

      // Software clears come first so hardware sets win
      if (wr_lo & (wb_adr_i == OFS_STAT))
      begin
         if (wb_dat_i[BIT_PVIOL])
            nxt_st.pviol = 1'b0;
         if (wb_dat_i[BIT_ACCERR])
            nxt_st.accerr = 1'b0;
      end

      // Command writing sequence: address, data, command, launch
      if (wr)
      begin
         case (wb_adr_i)
            OFS_ADDR:
            begin
               if (!st_ff.cbef)
               begin
                  nxt_st.accerr = 1'b1;
                  nxt_st.seq    = SEQ_NONE;
               end
               else
                  nxt_st.addr = wb_dat_i[AW-1:0];
            end
            OFS_DATA:
            begin
               if (!st_ff.cbef || st_ff.seq == SEQ_CMD)
               begin
                  nxt_st.accerr = 1'b1;
                  nxt_st.seq    = SEQ_NONE;
               end
               else if (wb_sel_i[0])
               begin
                  nxt_st.data = wb_dat_i[7:0];
                  nxt_st.seq  = SEQ_DATA;
               end
            end
            OFS_CMD:
            begin
               if (!st_ff.cbef || st_ff.seq != SEQ_DATA || !valid_cmd)
               begin
                  nxt_st.accerr = 1'b1;
                  nxt_st.seq    = SEQ_NONE;
               end
               else if (wb_sel_i[0])
               begin
                  nxt_st.cmd = wb_dat_i[7:0];
                  nxt_st.seq = SEQ_CMD;
               end
            end
            OFS_DIV:
            begin
               if (wb_sel_i[0])
               begin
                  nxt_st.div      = wb_dat_i[DIV_W-1:0];
                  nxt_st.div_init = 1'b1;
               end
            end
            OFS_PROT:
            begin
               nxt_st.prot_base = wb_dat_i[AW-1:0];
               nxt_st.prot_en   = wb_dat_i[BIT_PROT_EN];
            end
            OFS_IRQ_MASK: nxt_st.irq_mask = wb_dat_i[IRQ_W-1:0];
            default:      nxt_st.seq = st_ff.seq;  // Other offsets leave the sequence
         endcase
      end

      // Launch outcome
      if (launch_ae)
      begin
         nxt_st.accerr = 1'b1;
         nxt_st.seq    = SEQ_NONE;
      end
      else if (launch_pv)
      begin
         nxt_st.pviol = 1'b1;
         nxt_st.seq   = SEQ_NONE;
      end
      else if (launch_ok)
      begin
         nxt_st.cbef      = 1'b0;
         nxt_st.blank     = 1'b0;
         nxt_st.buf_valid = 1'b1;
         nxt_st.buf_cmd   = st_ff.cmd;
         nxt_st.buf_addr  = st_ff.addr;
         nxt_st.buf_data  = st_ff.data;
         nxt_st.seq       = SEQ_NONE;
      end

      // Array engine
      if (done)
      begin
         if (st_ff.a_cmd == CMD_BLANK)
            nxt_st.blank = arr_blank_i;
         nxt_st.run = FCS_IDLE;
      end
      if (xfer)
      begin
         nxt_st.start     = 1'b1;
         nxt_st.run       = FCS_RUN;
         nxt_st.run_burst = (st_ff.buf_cmd == CMD_BURST);
         nxt_st.a_cmd     = st_ff.buf_cmd;
         nxt_st.a_addr    = st_ff.buf_addr;
         nxt_st.a_data    = st_ff.buf_data;
         nxt_st.buf_valid = 1'b0;
         nxt_st.cbef      = 1'b0;
      end

      // Stop while busy aborts everything
      if (stop_err)
      begin
         nxt_st.accerr    = 1'b1;
         nxt_st.abort     = 1'b1;
         nxt_st.start     = 1'b0;
         nxt_st.run       = FCS_IDLE;
         nxt_st.buf_valid = 1'b0;
      end

      // Buffer empty returns once the queue can take a burst
      if (!xfer && !launch_ok && !nxt_st.buf_valid &&
          (nxt_st.run == FCS_IDLE || nxt_st.run_burst))
         nxt_st.cbef = 1'b1;

      // Complete flag follows the engine, never software
      nxt_st.ccf = (nxt_st.run == FCS_IDLE) & ~nxt_st.buf_valid & nxt_st.cbef;

      // Sticky events, set wins over write-one clear
      ev[IRQ_DONE]   = nxt_st.ccf & ~st_ff.ccf;
      ev[IRQ_PVIOL]  = nxt_st.pviol & ~st_ff.pviol;
      ev[IRQ_ACCERR] = nxt_st.accerr & ~st_ff.accerr;
      if (wr & (wb_adr_i == OFS_IRQ_STS))
         nxt_st.irq_sts = st_ff.irq_sts & ~wb_dat_i[IRQ_W-1:0];
      nxt_st.irq_sts = nxt_st.irq_sts | ev;
      nxt_st.irq     = |(nxt_st.irq_sts & nxt_st.irq_mask);
   end

   //*******************************************************************
   // State register
   //*******************************************************************
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_ff           <= '0;
         st_ff.cbef      <= 1'b1;
         st_ff.ccf       <= 1'b1;
         st_ff.seq       <= SEQ_NONE;
         st_ff.run       <= FCS_IDLE;
         st_ff.div       <= DIV_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flip-flops
   assign wb_dat_o    = st_ff.rdat_ff;
   assign wb_ack_o    = st_ff.ack_ff;
   assign irq_o       = st_ff.irq;
   assign arr_start_o = st_ff.start;
   assign arr_abort_o = st_ff.abort;
   assign arr_cmd_o   = st_ff.a_cmd;
   assign arr_addr_o  = st_ff.a_addr;
   assign arr_data_o  = st_ff.a_data;
   assign arr_div_o   = st_ff.div;

   //*******************************************************************
   // Checks
   //*******************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   launch_clears_cbef_a: assert property (launch_ok && !stop_err |=> !st_ff.cbef && st_ff.buf_valid)
      else $error("accepted launch left buffer-empty set");
   xfer_clears_cbef_a: assert property (st_ff.start |-> !st_ff.cbef && st_ff.run == FCS_RUN)
      else $error("handover without buffer-empty clear");
   queue_only_burst_a: assert property (st_ff.buf_valid && st_ff.run == FCS_RUN |->
      st_ff.run_burst && st_ff.buf_cmd == CMD_BURST)
      else $error("non-burst command queued");
   ccf_meaning_a: assert property (st_ff.ccf |-> st_ff.run == FCS_IDLE && !st_ff.buf_valid)
      else $error("complete flag set while busy");
   ccf_launch_clear_a: assert property (launch_ok |=> !st_ff.ccf ##1 !st_ff.ccf)
      else $error("complete flag not cleared by launch");
   pviol_ignore_a: assert property (launch_pv |=> st_ff.pviol && !st_ff.buf_valid && !st_ff.start)
      else $error("protected command not ignored");
   pviol_clear_a: assert property (wr_lo && wb_adr_i == OFS_STAT && wb_dat_i[BIT_PVIOL]
      && !launch_pv |=> !st_ff.pviol)
      else $error("protection flag not cleared");
   seq_error_a: assert property (launch && st_ff.seq != SEQ_CMD && !xfer |=> st_ff.accerr && !st_ff.start)
      else $error("broken sequence not flagged");
   div_error_a: assert property (launch && is_pe && !st_ff.div_init |=> st_ff.accerr)
      else $error("divider unset not flagged");
   stop_error_a: assert property (stop_err |=> st_ff.accerr && st_ff.abort && st_ff.run == FCS_IDLE)
      else $error("stop while busy not flagged");
   accerr_keep_a: assert property (st_ff.accerr && !(wr_lo && wb_adr_i == OFS_STAT &&
      wb_dat_i[BIT_ACCERR]) |=> st_ff.accerr)
      else $error("access error lost without clear");
   blank_result_a: assert property (done && st_ff.a_cmd == CMD_BLANK && !launch_ok |=>
      st_ff.blank == $past(arr_blank_i))
      else $error("blank result not captured");
   stat_zero_a: assert property (st_ff.ack_ff && $past(wb_adr_i) == OFS_STAT |->
      wb_dat_o[3] == 1'b0 && wb_dat_o[1:0] == 2'b00)
      else $error("unused status bits not zero");

endmodule : fcs_flags

// *** fcs_flags_test.sv ***
`timescale 1ns/10ps
module fcs_flags_test;
   import fcs_pkg::*;

   //**********************************************************************
   // Signals
   //**********************************************************************
   logic             mclk;         // Clock
   logic             resetn;       // Reset, low active
   logic             cyc;          // Bus cycle
   logic             stb;          // Bus strobe
   logic             we;           // Bus write
   logic [7:0]       adr;          // Bus address
   logic [3:0]       sel;          // Bus lanes
   logic [31:0]      wdat;         // Bus write data
   logic [31:0]      dat_o;        // Bus read data
   logic [31:0]      rdat;         // Captured read data
   logic             ack;          // Bus acknowledge
   logic             irq;          // Interrupt
   logic             stop;         // Stop request
   logic             done;         // Array done pulse
   logic             blank;        // Array blank result
   logic             start;        // Array start
   logic             abort;        // Array abort
   logic [7:0]       acmd;         // Command to array
   logic [15:0]      aaddr;        // Address to array
   logic [7:0]       adata;        // Data to array
   logic [DIV_W-1:0] div;          // Divider to array
   logic [31:0]      seed;         // Random state
   logic [15:0]      a;            // Scenario address
   logic [7:0]       d;            // Scenario data
   logic             b;            // Scenario blank result
   int               miscompares;  // Mismatches
   int               cmp_count;    // Comparisons
   int               starts;       // Start pulses seen
   int               aborts;       // Abort pulses seen
   int               i;            // Loop index
   int               n;            // Count snapshot
   int               m_pv, m_ae, m_bl, m_busy, m_nb, m_q;  // Flag model

   fcs_flags #(.AW(16)) dut
   (
      .mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .irq_o(irq), .stop_i(stop), .arr_done_i(done), .arr_blank_i(blank),
      .arr_start_o(start), .arr_abort_o(abort), .arr_cmd_o(acmd), .arr_addr_o(aaddr),
      .arr_data_o(adata), .arr_div_o(div)
   );

   //**********************************************************************
   // Clock and array pulse monitor
   //**********************************************************************
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Counts pulses as sampled at each edge
   always @(posedge mclk)
   begin
      if (start === 1'b1) starts++;
      if (abort === 1'b1) aborts++;
   end

   //**********************************************************************
   // Model, compares and bus tasks
   //**********************************************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Expected status word from the flag model
   function automatic logic [31:0] mstat();
      return {24'h0, m_q == 0 && m_nb == 0, m_busy == 0 && m_q == 0, m_pv != 0, m_ae != 0,
              1'b0, m_bl != 0, 2'h0};
   endfunction : mstat

   task automatic stop_test();
      $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD reg t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD pin t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_pin

   // One classic cycle, held until ack is sampled, then one idle cycle
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
      int k;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= dt;
      sel <= 4'hF;
      @(posedge mclk);
      for (k = 1; k < 20 && ack !== 1'b1; k++) @(posedge mclk);
      if (ack !== 1'b1)
      begin
         miscompares++;
         stop_test();
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      bus(1'b1, ad, dt);
   endtask : wr

   task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
      bus(1'b0, ad, 32'h0);
      chk_reg(rdat, e);
   endtask : rdc

   // Full command sequence ending in the launch write
   task automatic launch(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] dt);
      wr(OFS_ADDR, {16'h0, ad});
      wr(OFS_DATA, {24'h0, dt});
      wr(OFS_CMD, {24'h0, c});
      wr(OFS_STAT, 32'h80);
      repeat (4) @(posedge mclk);
   endtask : launch

   task automatic pulse_done(input logic bl);
      done <= 1'b1;
      blank <= bl;
      @(posedge mclk);
      done <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : pulse_done

   //**********************************************************************
   // Main sequence
   //**********************************************************************
   initial
   begin
      {cyc, stb, we, adr, sel, wdat, stop, done, blank} = '0;
      {miscompares, cmp_count, starts, aborts, m_pv, m_ae, m_bl, m_busy, m_nb, m_q} = '0;
      seed = 32'h9E53AC89;
      resetn = 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rdc(OFS_STAT, mstat());  // Idle after reset
      wr(OFS_STAT, 32'h4F);
      rdc(OFS_STAT, mstat());  // Plain flag writes ignored
      // Program with no divider set is refused
      launch(CMD_PROG, 16'h0000, 8'h5A);
      m_ae = 1;
      rdc(OFS_STAT, mstat());  // Divider never written
      chk_pin(32'(starts), 32'h0);  // Nothing sent to array
      wr(OFS_STAT, 32'h00);
      rdc(OFS_STAT, mstat());  // Zero keeps the error
      wr(OFS_STAT, 32'h10);
      m_ae = 0;
      rdc(OFS_STAT, mstat());  // One clears the error
      wr(OFS_DIV, 32'h1F);
      chk_pin({25'h0, div}, 32'h1F);  // Divider passed on
      // Command written without data
      wr(OFS_CMD, {24'h0, CMD_PROG});
      wr(OFS_STAT, 32'h80);
      repeat (4) @(posedge mclk);
      m_ae = 1;
      rdc(OFS_STAT, mstat());  // Broken sequence
      wr(OFS_STAT, 32'h10);
      m_ae = 0;
      // Every command code runs once
      for (i = 1; i <= 5; i++)
      begin
         a = 16'(xs() & 32'h7FFF);
         d = 8'(xs());
         n = starts;
         launch(8'(i), a, d);
         m_busy = 1;
         m_nb = (i != 3);
         m_bl = 0;
         chk_pin(32'(starts - n), 32'h1);  // One start per launch
         chk_pin({24'h0, acmd}, 32'(i));  // Command handed on
         chk_pin({aaddr, adata}, {a, d});  // Operands handed on
         rdc(OFS_STAT, mstat());  // Running flags
         b = (i == 1) ? 1'b1 : 1'(xs());
         pulse_done(b);
         m_busy = 0;
         m_nb = 0;
         m_bl = (i == 1) && b;
         rdc(OFS_STAT, mstat());  // Finished flags
      end
      // Program into a protected block
      wr(OFS_PROT, 32'h80008000);
      n = starts;
      launch(CMD_PROG, 16'h9000, 8'h11);
      m_pv = 1;
      chk_pin(32'(starts - n), 32'h0);  // Command ignored
      rdc(OFS_STAT, mstat());  // Violation raised
      wr(OFS_STAT, 32'h20);
      m_pv = 0;
      rdc(OFS_STAT, mstat());  // One clears violation
      wr(OFS_PROT, 32'h0);
      // Burst queue one deep, then a refused third launch
      n = starts;
      launch(CMD_BURST, 16'h0010, 8'(xs()));
      m_busy = 1;
      rdc(OFS_STAT, mstat());  // Buffer free while burst runs
      launch(CMD_BURST, 16'h0011, 8'(xs()));
      m_q = 1;
      rdc(OFS_STAT, mstat());  // Buffer full
      launch(CMD_BURST, 16'h0012, 8'h00);
      m_ae = 1;
      rdc(OFS_STAT, mstat());  // Launch into full buffer refused
      wr(OFS_STAT, 32'h10);
      m_ae = 0;
      pulse_done(1'b0);
      m_q = 0;
      chk_pin(32'(starts - n), 32'h2);  // Queued burst handed over
      chk_pin({16'h0, aaddr}, 32'h0011);  // Queued address
      rdc(OFS_STAT, mstat());  // Buffer empty again
      pulse_done(1'b0);
      m_busy = 0;
      rdc(OFS_STAT, mstat());  // All done
      // Stop while a page erase runs
      n = aborts;
      launch(CMD_PAGE, 16'h0100, 8'h00);
      stop <= 1'b1;
      @(posedge mclk);
      stop <= 1'b0;
      repeat (3) @(posedge mclk);
      m_ae = 1;
      chk_pin(32'(aborts - n), 32'h1);  // Array aborted
      rdc(OFS_STAT, mstat());  // Stop error
      wr(OFS_STAT, 32'h10);
      m_ae = 0;
      // Completion interrupt raised, masked and cleared
      wr(OFS_IRQ_STS, 32'h7);
      wr(OFS_IRQ_MASK, 32'h1);
      chk_pin({31'h0, irq}, 32'h0);  // Quiet after clear
      launch(CMD_BLANK, 16'h0000, 8'h00);
      pulse_done(1'b0);
      rdc(OFS_STAT, mstat());  // Blank check failed
      chk_pin({31'h0, irq}, 32'h1);  // Completion event
      rdc(OFS_IRQ_STS, 32'h1);  // Sticky completion
      wr(OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge mclk);
      chk_pin({31'h0, irq}, 32'h0);  // Masked
      wr(OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge mclk);
      chk_pin({31'h0, irq}, 32'h1);  // Unmasked
      wr(OFS_IRQ_STS, 32'h1);
      repeat (2) @(posedge mclk);
      chk_pin({31'h0, irq}, 32'h0);  // Cleared
      wr(8'h20, xs());
      rdc(8'h20, 32'h0);  // Unmapped reads zero
      stop_test();
   end

endmodule : fcs_flags_test
